// file: hdl/ufc_params.svh
/*
 * Constants of the four-channel UART flow-control block: register map,
 * field positions, reset values, trigger tables and software flow codes.
 * Assumes a Wishbone slave with byte addresses, one 32-bit word per register.
 */
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

`define UFC_NUM_CH       4
`define UFC_FIFO_DEPTH   64
`define UFC_FIFO_AW      6
`define UFC_RX_W         11
`define UFC_CH_W         8

`define UFC_ADR_CH_HI    7
`define UFC_ADR_CH_LO    6
`define UFC_ADR_REG_HI   5
`define UFC_ADR_REG_LO   2

`define UFC_REG_DATA     4'h0
`define UFC_REG_DIV      4'h1
`define UFC_REG_FCR      4'h2
`define UFC_REG_MCR      4'h3
`define UFC_REG_EFR      4'h4
`define UFC_REG_TCR      4'h5
`define UFC_REG_TLR      4'h6
`define UFC_REG_RSM_A    4'h7
`define UFC_REG_RSM_B    4'h8
`define UFC_REG_PSE_A    4'h9
`define UFC_REG_PSE_B    4'hA
`define UFC_REG_STATUS   4'hB

`define UFC_FCR_EN       0
`define UFC_FCR_RXCLR    1
`define UFC_FCR_TXCLR    2
`define UFC_MCR_RTS      1
`define UFC_EFR_ACTS     7
`define UFC_EFR_ARTS     6
`define UFC_ST_CTS_DELTA 21

`define UFC_DIV_RST      16'h0001
`define UFC_REG8_RST     8'h00
`define UFC_ONE          16'h0001
`define UFC_LVL_ONE      7'h01
`define UFC_LVL_ZERO     7'h00
`define UFC_NIB_ZERO     4'h0

`define UFC_RX_TRIG0     7'h08
`define UFC_RX_TRIG1     7'h10
`define UFC_RX_TRIG2     7'h38
`define UFC_RX_TRIG3     7'h3C
`define UFC_TX_TRIG0     7'h08
`define UFC_TX_TRIG1     7'h10
`define UFC_TX_TRIG2     7'h20
`define UFC_TX_TRIG3     7'h38

`define UFC_SW_NONE      2'b00
`define UFC_SW_A         2'b10
`define UFC_SW_B         2'b01
`define UFC_SW_AB        2'b11
`define UFC_LAST_BIT     3'h7

`endif

// file: hdl/ufc_pkg.sv
/*
 * Types shared by the flow-control block.
 * Assumes ufc_params.svh supplies every numeric constant.
 */
package ufc_pkg;
    typedef enum logic [1:0] {
        UFC_IDLE  = 2'b00,
        UFC_START = 2'b01,
        UFC_DATA  = 2'b10,
        UFC_STOP  = 2'b11
    } ufc_line_st_t;
endpackage

// file: hdl/ufc_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes din is asynchronous to clk; the output moves only once stages two and three agree.
 */
`timescale 1ns/10ps
`default_nettype none
module ufc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Data
    input  wire logic din,
    output var  logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/ufc_fifo.sv
/*
 * Synchronous show-ahead FIFO with occupancy count and clear.
 * Assumes push is ignored when full and pop when empty.
 */
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo #(
    parameter int W     = 8,
    parameter int AW    = 6,
    parameter int DEPTH = 64
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          clear,
    // Write side
    input  wire logic          push,
    input  wire logic [W-1:0]  wdata,
    // Read side
    input  wire logic          pop,
    output logic      [W-1:0]  rdata,
    // Status
    output logic      [AW:0]   count,
    output logic               full,
    output logic               empty
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push_ok;
    logic          pop_ok;

    // Count is one bit wider than the pointers so a full FIFO is told apart from an empty one
    assign full    = cnt_q == (AW+1)'(DEPTH);
    assign empty   = cnt_q == '0;
    assign push_ok = push & ~full;
    assign pop_ok  = pop & ~empty;
    assign rdata   = mem[rd_q];
    assign count   = cnt_q;

    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem[wr_q] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clear) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + AW'(push_ok);
            rd_q  <= rd_q + AW'(pop_ok);
            cnt_q <= cnt_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
        end
    end
endmodule
`default_nettype wire

// file: hdl/ufc_top.sv
/*
 * Four-channel UART core with FIFOs, trigger levels, DMA ready outputs,
 * automatic RTS/CTS and transmitted Xon/Xoff flow control, behind a classic
 * Wishbone slave. Assumes 8N1 framing, one bit time equal to divisor clocks,
 * and serial inputs asynchronous to clk.
 */
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "ufc_params.svh"
module ufc_top
    import ufc_pkg::*;
#(
    parameter int NUM_CH = `UFC_NUM_CH,
    parameter int DEPTH  = `UFC_FIFO_DEPTH,
    parameter int AW     = `UFC_FIFO_AW
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output var  logic [31:0]       wb_dat_o,
    output var  logic              wb_ack_o,
    // Serial side, one bit per channel
    input  wire logic [NUM_CH-1:0] rx_in,
    input  wire logic [NUM_CH-1:0] cts_in_n,
    output logic      [NUM_CH-1:0] tx_out,
    output logic      [NUM_CH-1:0] rts_out_n,
    // DMA signalling, active low
    output logic      [NUM_CH-1:0] rx_ready_out_n,
    output logic      [NUM_CH-1:0] tx_ready_out_n
);
    // Decode of one register of one channel during the address phase
    function automatic logic reg_hit(input logic req, input logic [7:0] adr, input int ch, input logic [3:0] idx);
        return req && (adr[`UFC_ADR_CH_HI:`UFC_ADR_CH_LO] == 2'(ch))
                   && (adr[`UFC_ADR_REG_HI:`UFC_ADR_REG_LO] == idx);
    endfunction

    // Effective trigger: one byte with FIFOs off, else the programmed level, else the selected one
    function automatic logic [6:0] trig_level(input logic fifo_en, input logic [3:0] prog,
                                              input logic [1:0] sel, input logic is_rx);
        logic [6:0] lvl;
        lvl = `UFC_LVL_ONE;
        if (!fifo_en) begin
            lvl = `UFC_LVL_ONE;
        end else if (prog != `UFC_NIB_ZERO) begin
            lvl = {1'b0, prog, 2'b00};
        end else begin
            unique case (sel)
                2'b00: lvl = is_rx ? `UFC_RX_TRIG0 : `UFC_TX_TRIG0;
                2'b01: lvl = is_rx ? `UFC_RX_TRIG1 : `UFC_TX_TRIG1;
                2'b10: lvl = is_rx ? `UFC_RX_TRIG2 : `UFC_TX_TRIG2;
                2'b11: lvl = is_rx ? `UFC_RX_TRIG3 : `UFC_TX_TRIG3;
            endcase
        end
        return lvl;
    endfunction

    // Nibble-coded flow level, four characters per step
    function automatic logic [6:0] nib_level(input logic [3:0] nib);
        return {1'b0, nib, 2'b00};
    endfunction

    logic        ack_q;
    logic [31:0] ch_rdata [NUM_CH];
    wire         bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
    wire         bus_rd  = bus_req & ~wb_we_i;
    wire  [1:0]  bus_ch  = wb_adr_i[`UFC_ADR_CH_HI:`UFC_ADR_CH_LO];

    // One-cycle answer to every access; unmapped reads return zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q    <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack_q    <= bus_req;
            wb_dat_o <= bus_rd ? ch_rdata[bus_ch] : '0;
        end
    end
    assign wb_ack_o = ack_q;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [15:0]            div_q;
        logic [7:0]             fcr_q;
        logic [7:0]             mcr_q;
        logic [7:0]             efr_q;
        logic [7:0]             tcr_q;
        logic [7:0]             tlr_q;
        logic [7:0]             rsm_a_q;
        logic [7:0]             rsm_b_q;
        logic [7:0]             pse_a_q;
        logic [7:0]             pse_b_q;
        logic                   rx_s;
        logic                   cts_s_n;
        logic                   cts_prev_q;
        logic                   cts_delta_q;
        logic [`UFC_RX_W-1:0]   rx_head;
        logic [`UFC_CH_W-1:0]   tx_head;
        logic [AW:0]            rx_cnt;
        logic [AW:0]            tx_cnt;
        logic                   rx_full;
        logic                   rx_empty;
        logic                   tx_full;
        logic                   tx_empty;
        ufc_line_st_t           tx_st_q;
        ufc_line_st_t           rx_st_q;
        logic [15:0]            tx_tm_q;
        logic [15:0]            rx_tm_q;
        logic [2:0]             tx_bit_q;
        logic [2:0]             rx_bit_q;
        logic [7:0]             tx_sh_q;
        logic [7:0]             rx_sh_q;
        logic                   tx_q;
        logic                   rts_flow_q;
        logic                   rts_n_q;
        logic                   rxr_n_q;
        logic                   txr_n_q;
        logic                   xoff_sent_q;
        logic [1:0]             sw_pend_q;

        wire wr_data = bus_wr & reg_hit(bus_req, wb_adr_i, c, `UFC_REG_DATA);
        wire rd_data = bus_rd & reg_hit(bus_req, wb_adr_i, c, `UFC_REG_DATA);
        wire wr_fcr  = bus_wr & reg_hit(bus_req, wb_adr_i, c, `UFC_REG_FCR);
        wire wr_st   = bus_wr & reg_hit(bus_req, wb_adr_i, c, `UFC_REG_STATUS);
        wire fifo_en = fcr_q[`UFC_FCR_EN];
        wire rx_clr  = wr_fcr & wb_dat_i[`UFC_FCR_RXCLR];
        wire tx_clr  = wr_fcr & wb_dat_i[`UFC_FCR_TXCLR];
        // Outside FIFO mode each direction behaves as a single holding register
        wire rx_full_eff = fifo_en ? rx_full : ~rx_empty;
        wire tx_full_eff = fifo_en ? tx_full : ~tx_empty;

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                div_q   <= `UFC_DIV_RST;
                fcr_q   <= `UFC_REG8_RST;
                mcr_q   <= `UFC_REG8_RST;
                efr_q   <= `UFC_REG8_RST;
                tcr_q   <= `UFC_REG8_RST;
                tlr_q   <= `UFC_REG8_RST;
                rsm_a_q <= `UFC_REG8_RST;
                rsm_b_q <= `UFC_REG8_RST;
                pse_a_q <= `UFC_REG8_RST;
                pse_b_q <= `UFC_REG8_RST;
            end else if (bus_wr && bus_ch == 2'(c)) begin
                unique case (wb_adr_i[`UFC_ADR_REG_HI:`UFC_ADR_REG_LO])
                    `UFC_REG_DIV:   div_q   <= {wb_sel_i[1] ? wb_dat_i[15:8] : div_q[15:8], wb_dat_i[7:0]};
                    `UFC_REG_FCR:   fcr_q   <= wb_dat_i[7:0] & ~8'h06;
                    `UFC_REG_MCR:   mcr_q   <= wb_dat_i[7:0];
                    `UFC_REG_EFR:   efr_q   <= wb_dat_i[7:0];
                    `UFC_REG_TCR:   tcr_q   <= wb_dat_i[7:0];
                    `UFC_REG_TLR:   tlr_q   <= wb_dat_i[7:0];
                    `UFC_REG_RSM_A: rsm_a_q <= wb_dat_i[7:0];
                    `UFC_REG_RSM_B: rsm_b_q <= wb_dat_i[7:0];
                    `UFC_REG_PSE_A: pse_a_q <= wb_dat_i[7:0];
                    `UFC_REG_PSE_B: pse_b_q <= wb_dat_i[7:0];
                    default: ;
                endcase
            end
        end

        ufc_sync #(.RST_VAL(1'b1)) u_rx_sync (
            .clk    (clk),
            .resetn (resetn),
            .din    (rx_in[c]),
            .dout   (rx_s)
        );
        ufc_sync #(.RST_VAL(1'b1)) u_cts_sync (
            .clk    (clk),
            .resetn (resetn),
            .din    (cts_in_n[c]),
            .dout   (cts_s_n)
        );

        // Divisor zero is treated as one so the bit timer never stalls
        wire [15:0] div_eff = (div_q == '0) ? `UFC_ONE : div_q;
        wire        tx_tick = tx_tm_q == div_eff - `UFC_ONE;
        wire        rx_tick = rx_tm_q == div_eff - `UFC_ONE;
        wire        rx_half = rx_tm_q == {1'b0, div_eff[15:1]};

        wire        cts_ok    = ~efr_q[`UFC_EFR_ACTS] | ~cts_s_n;
        wire [1:0]  sw_mode   = efr_q[3:2];
        wire        sw_en     = sw_mode != `UFC_SW_NONE;
        wire        sw_use_b  = (sw_mode == `UFC_SW_B) || (sw_mode == `UFC_SW_AB && sw_pend_q == 2'd1);
        wire [7:0]  sw_char   = xoff_sent_q ? (sw_use_b ? pse_b_q : pse_a_q) : (sw_use_b ? rsm_b_q : rsm_a_q);
        wire [1:0]  sw_count  = (sw_mode == `UFC_SW_AB) ? 2'd2 : 2'd1;
        wire        tx_idle   = tx_st_q == UFC_IDLE;
        wire        start_sw  = tx_idle && sw_pend_q != 2'd0;
        // CTS is looked at only here, at the start of a character
        wire        start_dat = tx_idle && sw_pend_q == 2'd0 && !tx_empty && cts_ok;
        wire [6:0]  halt_lvl  = nib_level(tcr_q[3:0]);
        wire [6:0]  rsm_lvl   = nib_level(tcr_q[7:4]);
        wire        go_pause  = sw_en && !xoff_sent_q && sw_pend_q == 2'd0 && rx_cnt > halt_lvl;
        wire        go_resume = sw_en && xoff_sent_q && sw_pend_q == 2'd0 && rx_cnt <= rsm_lvl;
        wire        rx_push   = rx_st_q == UFC_STOP && rx_tick && !rx_full_eff;
        wire        rx_frm    = ~rx_s;
        wire [2:0]  rx_err    = {rx_frm & (rx_sh_q == '0), rx_frm, 1'b0};
        wire [6:0]  rx_trig   = trig_level(fifo_en, tlr_q[7:4], fcr_q[7:6], 1'b1);
        wire [6:0]  tx_trig   = trig_level(fifo_en, tlr_q[3:0], fcr_q[5:4], 1'b0);
        wire [6:0]  tx_space  = fifo_en ? 7'(DEPTH) - tx_cnt : (tx_empty ? `UFC_LVL_ONE : `UFC_LVL_ZERO);

        ufc_fifo #(.W(`UFC_RX_W), .AW(AW), .DEPTH(DEPTH)) u_rx_fifo (
            .clk    (clk),
            .resetn (resetn),
            .clear  (rx_clr),
            .push   (rx_push),
            .wdata  ({rx_err, rx_sh_q}),
            .pop    (rd_data),
            .rdata  (rx_head),
            .count  (rx_cnt),
            .full   (rx_full),
            .empty  (rx_empty)
        );
        ufc_fifo #(.W(`UFC_CH_W), .AW(AW), .DEPTH(DEPTH)) u_tx_fifo (
            .clk    (clk),
            .resetn (resetn),
            .clear  (tx_clr),
            .push   (wr_data & ~tx_full_eff),
            .wdata  (wb_dat_i[7:0]),
            .pop    (start_dat),
            .rdata  (tx_head),
            .count  (tx_cnt),
            .full   (tx_full),
            .empty  (tx_empty)
        );

        // Transmitter: a started character always runs to its stop bit
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                tx_st_q  <= UFC_IDLE;
                tx_tm_q  <= '0;
                tx_bit_q <= '0;
                tx_sh_q  <= '0;
                tx_q     <= 1'b1;
            end else if (tx_idle) begin
                tx_tm_q  <= '0;
                tx_bit_q <= '0;
                if (start_sw || start_dat) begin
                    tx_st_q <= UFC_START;
                    tx_sh_q <= start_sw ? sw_char : tx_head;
                    tx_q    <= 1'b0;
                end
            end else if (!tx_tick) begin
                tx_tm_q <= tx_tm_q + `UFC_ONE;
            end else begin
                tx_tm_q <= '0;
                unique case (tx_st_q)
                    UFC_START: begin
                        tx_st_q <= UFC_DATA;
                        tx_q    <= tx_sh_q[0];
                    end
                    UFC_DATA: begin
                        tx_bit_q <= tx_bit_q + 3'd1;
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_q     <= (tx_bit_q == `UFC_LAST_BIT) ? 1'b1 : tx_sh_q[1];
                        if (tx_bit_q == `UFC_LAST_BIT) begin
                            tx_st_q <= UFC_STOP;
                        end
                    end
                    UFC_STOP: tx_st_q <= UFC_IDLE;
                    UFC_IDLE: tx_st_q <= UFC_IDLE;
                endcase
            end
        end

        // Receiver: sampling points sit at the middle of each bit
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                rx_st_q  <= UFC_IDLE;
                rx_tm_q  <= '0;
                rx_bit_q <= '0;
                rx_sh_q  <= '0;
            end else begin
                rx_tm_q <= (rx_st_q == UFC_IDLE || rx_tick || (rx_st_q == UFC_START && rx_half)) ? '0
                           : rx_tm_q + `UFC_ONE;
                unique case (rx_st_q)
                    UFC_IDLE:  if (!rx_s) rx_st_q <= UFC_START;
                    UFC_START: if (rx_half) rx_st_q <= rx_s ? UFC_IDLE : UFC_DATA;
                    UFC_DATA: if (rx_tick) begin
                        rx_sh_q  <= {rx_s, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'd1;
                        if (rx_bit_q == `UFC_LAST_BIT) rx_st_q <= UFC_STOP;
                    end
                    UFC_STOP:  if (rx_tick) rx_st_q <= UFC_IDLE;
                endcase
            end
        end

        // Flow control state and registered pin drivers
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                rts_flow_q  <= 1'b1;
                rts_n_q     <= 1'b1;
                rxr_n_q     <= 1'b1;
                txr_n_q     <= 1'b0;
                xoff_sent_q <= 1'b0;
                sw_pend_q   <= 2'd0;
            end else begin
                if (rx_cnt >= halt_lvl) begin
                    rts_flow_q <= 1'b0;
                end else if (rx_cnt <= rsm_lvl) begin
                    rts_flow_q <= 1'b1;
                end
                rts_n_q <= efr_q[`UFC_EFR_ARTS] ? ~rts_flow_q : ~mcr_q[`UFC_MCR_RTS];
                rxr_n_q <= ~(rx_cnt >= rx_trig);
                txr_n_q <= ~(tx_space >= tx_trig);
                if (go_pause || go_resume) begin
                    xoff_sent_q <= go_pause;
                    sw_pend_q   <= sw_count;
                end else if (start_sw) begin
                    sw_pend_q   <= sw_pend_q - 2'd1;
                end
            end
        end

        // Sticky CTS change flag, set only with auto CTS off; there a new change wins over a clear in the same cycle
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                cts_prev_q  <= 1'b1;
                cts_delta_q <= 1'b0;
            end else begin
                cts_prev_q  <= cts_s_n;
                if (cts_s_n != cts_prev_q && !efr_q[`UFC_EFR_ACTS]) begin
                    cts_delta_q <= 1'b1;
                end else if (wr_st && wb_dat_i[`UFC_ST_CTS_DELTA]) begin
                    cts_delta_q <= 1'b0;
                end
            end
        end

        wire [3:0]  rsel = wb_adr_i[`UFC_ADR_REG_HI:`UFC_ADR_REG_LO];
        // Only the data register pops on read; status reads leave the channel untouched
        wire [31:0] status_w = {10'h000, cts_delta_q, xoff_sent_q, ~tx_idle, ~cts_s_n, ~rts_n_q, ~rxr_n_q,
                                ~txr_n_q, tx_cnt, rx_empty, rx_cnt};
        assign ch_rdata[c] = (rsel == `UFC_REG_DATA)   ? {21'h00_0000, rx_empty ? 11'h000 : rx_head} :
                             (rsel == `UFC_REG_DIV)    ? {16'h0000, div_q} :
                             (rsel == `UFC_REG_FCR)    ? {24'h00_0000, fcr_q} :
                             (rsel == `UFC_REG_MCR)    ? {24'h00_0000, mcr_q} :
                             (rsel == `UFC_REG_EFR)    ? {24'h00_0000, efr_q} :
                             (rsel == `UFC_REG_TCR)    ? {24'h00_0000, tcr_q} :
                             (rsel == `UFC_REG_TLR)    ? {24'h00_0000, tlr_q} :
                             (rsel == `UFC_REG_RSM_A)  ? {24'h00_0000, rsm_a_q} :
                             (rsel == `UFC_REG_RSM_B)  ? {24'h00_0000, rsm_b_q} :
                             (rsel == `UFC_REG_PSE_A)  ? {24'h00_0000, pse_a_q} :
                             (rsel == `UFC_REG_PSE_B)  ? {24'h00_0000, pse_b_q} :
                             (rsel == `UFC_REG_STATUS) ? status_w : 32'h0000_0000;

        assign tx_out[c]         = tx_q;
        assign rts_out_n[c]      = rts_n_q;
        assign rx_ready_out_n[c] = rxr_n_q;
        assign tx_ready_out_n[c] = txr_n_q;
    end
endmodule
`default_nettype wire

// file: sim/ufc_checker.sv
/* Checker on ufc_top ports: bus answers, reset pins, manual RTS.
   Assumes channel 3 keeps auto RTS off. */
`timescale 1ns/10ps
`default_nettype none
module ufc_checker #(parameter int NUM_CH = 4) (
    // Clock
    input wire logic              clk,
    input wire logic              resetn,
    // Bus
    input wire logic              wb_cyc_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    // Pins
    input wire logic [NUM_CH-1:0] rts_out_n
);
    wire logic req = wb_cyc_i && !wb_ack_o;
    wire logic modem_control_reg = wb_adr_i == 8'hCC;
    logic      mcr_q;
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            mcr_q <= 1'b0;
        else if (req && wb_we_i && modem_control_reg)
            mcr_q <= wb_dat_i[1];
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_late: assert property (req |=> wb_ack_o) else $error("ack late");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i)) else $error("stray ack");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("stray data");
    a_mcr_back: assert property (req && !wb_we_i && modem_control_reg |=> wb_dat_o[1] == mcr_q) else $error("readback");
    a_tcr_bytes: assert property (req && wb_adr_i[5:2] == 4'h5 |=> wb_dat_o[31:8] == 24'h00_0000) else $error("tcr");
    a_rts_reset: assert property ($rose(resetn) |-> &rts_out_n) else $error("rts low");
    a_rts_manual: assert property ($stable(mcr_q) [*3] |-> rts_out_n[3] == !mcr_q) else $error("rts");
endmodule
bind ufc_top ufc_checker #(.NUM_CH(NUM_CH)) ufc_checker_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rts_out_n(rts_out_n));
`default_nettype wire

// file: sim/ufc_remote.sv
/* Remote sender on one channel: 8N1 frames and CTS.
   Assumes the device divisor equals DIV. */
`timescale 1ns/10ps
`default_nettype none
module ufc_remote #(parameter int DIV = 4) (
    // Link
    input  wire logic clk,
    input  wire logic hold,
    output var  logic rx,
    output var  logic cts_n
);
    initial rx = 1'b1;
    always_comb cts_n = hold;
    // Ignores RTS on purpose: new frames still start while RTS is high
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (DIV) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// file: sim/ufc_top_tb.sv
/* Bench for ufc_top, remote model on channel 0.
   Assumes a divisor of four clocks a bit. */
`timescale 1ns/10ps
`default_nettype none
module ufc_top_tb;
    logic        clk, resetn, cyc, we, hold, rx0, cts0, ack, s;
    logic [7:0]  adr;
    logic [31:0] wd, dout, rd;
    logic [3:0]  tx, rts_n, rxr_n, txr_n;
    int          fails, checked, ticks;
    ufc_top ufc_top_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack),
        .rx_in({3'h7, rx0}), .cts_in_n({3'h7, cts0}), .tx_out(tx), .rts_out_n(rts_n),
        .rx_ready_out_n(rxr_n), .tx_ready_out_n(txr_n));
    ufc_remote ufc_remote_inst (.clk(clk), .hold(hold), .rx(rx0), .cts_n(cts0));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 30000) begin
            fails++;
            close_out();
        end
    end
    task automatic cmp(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dout;
        cyc <= 1'b0;
    endtask
    task automatic tx_seen(input int n);
        s = 1'b0;
        repeat (n) begin
            @(posedge clk);
            s |= ~tx[0];
        end
    endtask
    task automatic t_rts;
        bus(1'b1, 8'h04, 32'h0000_0004);
        bus(1'b1, 8'h08, 32'h0000_0001);
        bus(1'b1, 8'h14, 32'h0000_0001);
        bus(1'b1, 8'h10, 32'h0000_0040);
        repeat (2) @(posedge clk);
        cmp(32'(rts_n[0]), 32'h0000_0000);
        cmp(32'(txr_n[0]), 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            ufc_remote_inst.send(8'hA0 + 8'(i));
        end
        repeat (8) @(posedge clk);
        cmp(32'(rts_n[0]), 32'h0000_0001);
        cmp(32'(rxr_n[0]), 32'h0000_0001);
        ufc_remote_inst.send(8'hA4);
        repeat (8) @(posedge clk);
        bus(1'b0, 8'h2C, 32'h0000_0000);
        cmp(32'(rd[6:0]), 32'h0000_0005);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'h00, 32'h0000_0000);
            cmp(32'(rd[10:0]), 32'(8'hA0 + 8'(i)));
        end
        repeat (2) @(posedge clk);
        cmp(32'(rts_n[0]), 32'h0000_0000);
    endtask
    task automatic t_cts;
        hold <= 1'b1;
        bus(1'b1, 8'h10, 32'h0000_0080);
        bus(1'b1, 8'h00, 32'h0000_0055);
        tx_seen(40);
        cmp(32'(s), 32'h0000_0000);
        hold <= 1'b0;
        tx_seen(60);
        cmp(32'(s), 32'h0000_0001);
        bus(1'b1, 8'h10, 32'h0000_0000);
        hold <= 1'b1;
        bus(1'b1, 8'h00, 32'h0000_0033);
        tx_seen(20);
        cmp(32'(s), 32'h0000_0001);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        {cyc, we, hold, adr, wd} = '0;
        repeat (3) @(posedge clk);
        cmp(32'({tx, rts_n, rxr_n, txr_n}), 32'h0000_FFF0);
        resetn <= 1'b1;
        bus(1'b1, 8'hCC, 32'h0000_0002);
        bus(1'b0, 8'hCC, 32'h0000_0000);
        cmp(rd, 32'h0000_0002);
        cmp(32'(rts_n[3]), 32'h0000_0000);
        t_rts;
        t_cts;
        close_out;
    end
endmodule
`default_nettype wire
